// >>> input_port_pkg.sv
// Shared constants for the 8-bit input port with interrupt and reset pattern
package input_port_pkg;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int         PIN_COUNT       = 8;
  localparam logic [7:0] PULLUP_RESET    = 8'h00;
  localparam logic [7:0] EDGE_RESET      = 8'h00;
  localparam logic [7:0] DEBOUNCE_RESET  = 8'h00;
  localparam logic [7:0] PATTERN_RESET   = 8'h00;
  localparam logic [7:0] ALL_ONES        = 8'hFF;
  // ----------------------------------------
  // Timing: filter clock rates and system clock
  // ----------------------------------------
  localparam longint SYS_CLK_HZ          = 200_000_000;
  localparam longint SLOW_FILTER_HZ      = 256;
  localparam longint FAST_FILTER_HZ      = 8_000;
  localparam longint SLOW_FILTER_CYCLES  = SYS_CLK_HZ / SLOW_FILTER_HZ;
  localparam longint FAST_FILTER_CYCLES  = SYS_CLK_HZ / FAST_FILTER_HZ;
  localparam int     TICK_COUNT_WIDTH    = 20;
  // ----------------------------------------
  // Debounce filter states
  // ----------------------------------------
  typedef enum logic [1:0] {
    DB_STABLE  = 2'b01,
    DB_PENDING = 2'b10
  } db_state_t;
endpackage : input_port_pkg

// >>> debounce_if.sv
// Connection between the port top and its debounce filter
`timescale 1ns/1ps
interface debounce_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] filtered;
  logic             sample_tick;
  modport top    (output raw, output sample_tick, input filtered);
  modport filter (input raw, input sample_tick, output filtered);
endinterface : debounce_if

// >>> pin_debouncer.sv
// Per-pin two-sample debounce filter driven by a sample tick
`timescale 1ns/1ps
module pin_debouncer #(
  parameter int WIDTH = 8
) (
  input  wire logic   SYS_CLK,
  input  wire logic   SYS_RST,
  debounce_if.filter  dbus
);
  import input_port_pkg::*;

  // ----------------------------------------
  // Two-sample filter, one state machine per pin
  // ----------------------------------------
  db_state_t        state_q [WIDTH];
  logic [WIDTH-1:0] cand_q;
  logic [WIDTH-1:0] filt_q;

  assign dbus.filtered = filt_q;

  // A change is accepted only when two ticks see the same new value
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        state_q[i] <= DB_STABLE;
        cand_q[i]  <= 1'b0;
        filt_q[i]  <= 1'b0;
      end else if (dbus.sample_tick) begin
        case (state_q[i])
          DB_STABLE: begin
            if (dbus.raw[i] != filt_q[i]) begin
              cand_q[i]  <= dbus.raw[i];
              state_q[i] <= DB_PENDING;
            end
          end
          DB_PENDING: begin
            if (dbus.raw[i] == cand_q[i]) begin
              filt_q[i] <= cand_q[i];
            end
            state_q[i] <= DB_STABLE;
          end
          default: state_q[i] <= DB_STABLE;
        endcase
      end
    end

    // Accepted value equals two consecutive equal samples
    filter_two_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      dbus.sample_tick && state_q[i] == DB_PENDING && dbus.raw[i] == cand_q[i]
      |=> filt_q[i] == $past(cand_q[i]))
      else $error("debounce did not accept a confirmed value");
  end
endmodule : pin_debouncer

// >>> input_port.sv
// Eight-pin input port: pull-ups, debounce, edge interrupts, events, reset pattern
// How it works
// - Pull-up enable bit 1 connects the pin pull-up; 0 leaves it floating.
// - After reset all pull-up enable bits are cleared.
// - Each of the eight pins is its own edge-triggered interrupt source.
// - After system reset every pin's interrupt edge is rising.
// - Debounce enable picks the filtered value for edge detection, else direct.
// - Edges are found on the polarity-adjusted input; edge bit changes may interrupt.
// - Interrupts of pins 0 and 1 also go out as events.
// - Pins 0 to 3, filtered or direct, feed the counters as clocks.
// - System reset request is the AND of the eight per-pin terms.
// - Bit pair 00 gives 0, 01 pin, 10 inverted pin, 11 one.
// - Both pattern registers all ones reset regardless of pins.
// - Pattern match is evaluated continuously on current pin values.
// - RC-on-pin-0 set with pin 0 high sets the RC oscillator enable.
// - Edge bit 0 selects the rising edge, 1 the falling edge.
// - Filter accepts a value after two equal samples at 256 Hz or 8 kHz.
// - Input status shows each pin filtered or direct per debounce bit.
`timescale 1ns/1ps
module input_port
  import input_port_pkg::*;
#(
  parameter int                      WIDTH       = 8,
  parameter logic [TICK_COUNT_WIDTH-1:0] SLOW_TICKS = TICK_COUNT_WIDTH'(SLOW_FILTER_CYCLES),
  parameter logic [TICK_COUNT_WIDTH-1:0] FAST_TICKS = TICK_COUNT_WIDTH'(FAST_FILTER_CYCLES)
) (
  input  wire logic             SYS_CLK,
  input  wire logic             SYS_RST,
  input  wire logic             PORT_CONF_RST,
  input  wire logic [WIDTH-1:0] PIN_IN,
  input  wire logic             CFG_WE,
  input  wire logic [WIDTH-1:0] PULLUP_ENABLE_IN,
  input  wire logic [WIDTH-1:0] EDGE_SELECT_IN,
  input  wire logic [WIDTH-1:0] DEBOUNCE_ENABLE_IN,
  input  wire logic [WIDTH-1:0] RESET_PATTERN_LOW_IN,
  input  wire logic [WIDTH-1:0] RESET_PATTERN_HIGH_IN,
  input  wire logic             FAST_FILTER_SELECT,
  input  wire logic             RC_ENABLE_FROM_PIN0,
  output logic      [WIDTH-1:0] PULLUP_ENABLE,
  output logic      [WIDTH-1:0] INPUT_STATUS,
  output logic      [WIDTH-1:0] IRQ_PULSE,
  output logic      [1:0]       EVENT_PULSE,
  output logic      [3:0]       COUNTER_CLK_SRC,
  output logic                  SYS_RESET_REQ,
  output logic                  RC_OSC_ENABLE_SET
);
  import input_port_pkg::*;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [WIDTH-1:0] pullup_enable_reg_q;
  logic [WIDTH-1:0] edge_select_reg_q;
  logic [WIDTH-1:0] debounce_enable_reg_q;
  logic [WIDTH-1:0] reset_pattern_low_reg_q;
  logic [WIDTH-1:0] reset_pattern_high_reg_q;

  // Pull-up and debounce enables clear on either reset source
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || PORT_CONF_RST) begin
      pullup_enable_reg_q   <= PULLUP_RESET;
      debounce_enable_reg_q <= DEBOUNCE_RESET;
    end else if (CFG_WE) begin
      pullup_enable_reg_q   <= PULLUP_ENABLE_IN;
      debounce_enable_reg_q <= DEBOUNCE_ENABLE_IN;
    end
  end

  // Edge and pattern registers clear only on system reset
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      edge_select_reg_q        <= EDGE_RESET;
      reset_pattern_low_reg_q  <= PATTERN_RESET;
      reset_pattern_high_reg_q <= PATTERN_RESET;
    end else if (CFG_WE) begin
      edge_select_reg_q        <= EDGE_SELECT_IN;
      reset_pattern_low_reg_q  <= RESET_PATTERN_LOW_IN;
      reset_pattern_high_reg_q <= RESET_PATTERN_HIGH_IN;
    end
  end

  // Pad pull-up control follows the enable register directly
  assign PULLUP_ENABLE = pullup_enable_reg_q;

  // ----------------------------------------
  // Filter clock and debouncer
  // ----------------------------------------
  logic [TICK_COUNT_WIDTH-1:0] tick_cnt_q;
  logic                        tick_q;
  logic [TICK_COUNT_WIDTH-1:0] tick_limit;

  assign tick_limit = FAST_FILTER_SELECT ? FAST_TICKS : SLOW_TICKS;

  // Free-running divider; a rate change applies at once to the running count
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= tick_limit - 1'b1) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  debounce_if #(.WIDTH(WIDTH)) dbus ();
  assign dbus.raw         = PIN_IN;
  assign dbus.sample_tick = tick_q;

  pin_debouncer #(.WIDTH(WIDTH)) u_debouncer (
    .SYS_CLK (SYS_CLK),
    .SYS_RST (SYS_RST),
    .dbus    (dbus.filter)
  );

  // ----------------------------------------
  // Selected input value and edge detection
  // ----------------------------------------
  logic [WIDTH-1:0] pin_value;
  logic [WIDTH-1:0] polar_d;
  logic [WIDTH-1:0] polar_q;
  logic [WIDTH-1:0] irq_d;

  // Per-pin choice between filtered and direct input
  assign pin_value = (debounce_enable_reg_q & dbus.filtered)
                   | (~debounce_enable_reg_q & PIN_IN);

  // Falling-edge pins are inverted so one rising detector serves both;
  // flipping the edge bit can therefore fire an interrupt by itself
  assign polar_d = pin_value ^ edge_select_reg_q;
  assign irq_d   = polar_d & ~polar_q;

  // Input status and counter clock copies
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      INPUT_STATUS    <= '0;
      COUNTER_CLK_SRC <= '0;
    end else begin
      INPUT_STATUS    <= pin_value;
      COUNTER_CLK_SRC <= pin_value[3:0];
    end
  end

  // Previous polarity and one-cycle interrupt pulses; the polarity is
  // seeded from the live pins in reset, so a pin already high is no edge
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      polar_q     <= PIN_IN ^ WIDTH'(EDGE_RESET);
      IRQ_PULSE   <= '0;
      EVENT_PULSE <= '0;
    end else begin
      polar_q     <= polar_d;
      IRQ_PULSE   <= irq_d;
      EVENT_PULSE <= irq_d[1:0];
    end
  end

  // ----------------------------------------
  // Reset pattern and RC enable
  // ----------------------------------------
  function automatic logic [WIDTH-1:0] reset_terms(
    input logic [WIDTH-1:0] hi,
    input logic [WIDTH-1:0] lo,
    input logic [WIDTH-1:0] pins
  );
    reset_terms = (hi & lo) | (~hi & lo & pins) | (hi & ~lo & ~pins);
  endfunction : reset_terms

  logic [WIDTH-1:0] pin_reset_term;

  // Continuous match on the live pins, so a write can reset at once;
  // software should keep one pair at 00 while rewriting
  assign pin_reset_term = reset_terms(reset_pattern_high_reg_q, reset_pattern_low_reg_q, PIN_IN);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SYS_RESET_REQ     <= 1'b0;
      RC_OSC_ENABLE_SET <= 1'b0;
    end else begin
      SYS_RESET_REQ     <= &pin_reset_term;
      RC_OSC_ENABLE_SET <= RC_ENABLE_FROM_PIN0 & pin_value[0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence rise_seen(int i);
    !polar_q[i] ##0 polar_d[i];
  endsequence

  irq_one_cycle_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    IRQ_PULSE[0] |=> !IRQ_PULSE[0])
    else $error("interrupt pulse held longer than one cycle");
  irq_edge_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    rise_seen(2) |=> IRQ_PULSE[2])
    else $error("qualifying edge gave no interrupt");
  falling_edge_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    edge_select_reg_q[1] && !debounce_enable_reg_q[1] && $past(PIN_IN[1]) && !PIN_IN[1]
    && $stable(edge_select_reg_q[1]) && !$past(debounce_enable_reg_q[1]) |=> IRQ_PULSE[1])
    else $error("falling edge missed with negative edge selected");
  event_copy_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    EVENT_PULSE == IRQ_PULSE[1:0])
    else $error("event outputs differ from pin 0 and 1 interrupts");
  soft_reset_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    reset_pattern_low_reg_q == ALL_ONES && reset_pattern_high_reg_q == ALL_ONES
    |=> SYS_RESET_REQ)
    else $error("all-ones pattern did not request reset");
  pattern_off_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (~reset_pattern_low_reg_q[0] && ~reset_pattern_high_reg_q[0]) |=> !SYS_RESET_REQ)
    else $error("reset requested with a 00 pair present");
  rc_enable_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    RC_ENABLE_FROM_PIN0 && !debounce_enable_reg_q[0] && PIN_IN[0] |=> RC_OSC_ENABLE_SET)
    else $error("rc enable not set from pin 0");
  status_direct_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !debounce_enable_reg_q[4] |=> INPUT_STATUS[4] == $past(PIN_IN[4]))
    else $error("status does not show direct pin value");
  // Looked at on the first edge after release, when the registers are settled
  pullup_reset_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $past(SYS_RST) |-> PULLUP_ENABLE == PULLUP_RESET && edge_select_reg_q == EDGE_RESET)
    else $error("configuration not cleared by reset");
  release_quiet_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $past(SYS_RST) && $stable(PIN_IN) |=> IRQ_PULSE == '0)
    else $error("false interrupt right after reset");
endmodule : input_port

// >>> pin_switch_model.sv
// Switches and pull-ups standing on the eight input pins
`timescale 1ns/1ps
module pin_switch_model (
  input  wire logic       SYS_CLK,
  input  wire logic [7:0] PULLUP_ENABLE,
  input  wire logic [7:0] SWITCH_CLOSED,
  input  wire logic [7:0] SWITCH_LEVEL,
  output logic      [7:0] PIN_LEVEL
);
  logic [7:0] float_q = 8'h00;
  // An open pin with no pull-up wanders, so it toggles every cycle
  always @(negedge SYS_CLK) begin
    float_q <= ~float_q;
  end
  // Closed switch wins, then the pull-up, else the wandering level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (SWITCH_CLOSED[i]) PIN_LEVEL[i] = SWITCH_LEVEL[i];
      else if (PULLUP_ENABLE[i]) PIN_LEVEL[i] = 1'b1;
      else PIN_LEVEL[i] = float_q[i];
    end
  end
endmodule : pin_switch_model

// >>> input_port_irq_reset_pattern_test.sv
// Self-checking bench for the eight-pin input port
`timescale 1ns/1ps
module input_port_irq_reset_pattern_test;
  import input_port_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       sys_clk = 1'b0, sys_rst = 1'b1, conf_rst = 1'b0, cfg_we = 1'b0;
  logic       fast_sel = 1'b0, rc_pin0 = 1'b0, reset_req, rc_set;
  logic [7:0] pu = 8'h00, edge_sel = 8'h00, deb = 8'h00, pat_lo = 8'h00, pat_hi = 8'h00;
  logic [7:0] sw_closed = 8'hFF, sw_level = 8'h00, pins, pullup_en, in_status, irq;
  logic [1:0] evt;
  logic [3:0] cnt_clk;
  int         mismatches = 0;
  int         n_tests = 0;
  // Short filter periods keep the debounce waits brief
  input_port #(.SLOW_TICKS(20'h0_0008), .FAST_TICKS(20'h0_0004)) i_dut (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .PORT_CONF_RST(conf_rst), .PIN_IN(pins),
    .CFG_WE(cfg_we), .PULLUP_ENABLE_IN(pu), .EDGE_SELECT_IN(edge_sel), .DEBOUNCE_ENABLE_IN(deb),
    .RESET_PATTERN_LOW_IN(pat_lo), .RESET_PATTERN_HIGH_IN(pat_hi), .FAST_FILTER_SELECT(fast_sel),
    .RC_ENABLE_FROM_PIN0(rc_pin0), .PULLUP_ENABLE(pullup_en), .INPUT_STATUS(in_status),
    .IRQ_PULSE(irq), .EVENT_PULSE(evt), .COUNTER_CLK_SRC(cnt_clk), .SYS_RESET_REQ(reset_req),
    .RC_OSC_ENABLE_SET(rc_set));
  pin_switch_model i_pins (.SYS_CLK(sys_clk), .PULLUP_ENABLE(pullup_en), .SWITCH_CLOSED(sw_closed),
    .SWITCH_LEVEL(sw_level), .PIN_LEVEL(pins));
  // 200 MHz clock
  initial forever #2.5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // All five buses load together on one strobe cycle
  task automatic write_cfg();
    cyc(1);
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
  endtask : write_cfg
  // Bounded wait for a pulse, then it must be gone a cycle later
  task automatic expect_pulse(input logic [7:0] exp);
    int k;
    k = 0;
    while (irq === 8'h00 && k < 20) begin
      cyc(1);
      k++;
    end
    check(irq, exp, "interrupt pulse");
    check({6'h00, evt}, {6'h00, exp[1:0]}, "event pulse");
    if (k == 20) begin
      mismatches++;
      print_verdict();
    end else begin
      cyc(1);
      check(irq, 8'h00, "pulse width");
    end
  endtask : expect_pulse
  task automatic expect_quiet();
    repeat (4) begin
      cyc(1);
      check(irq, 8'h00, "unexpected interrupt");
    end
  endtask : expect_quiet
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pullup();
    check(pullup_en, 8'h00, "pull-up reset");
    pu = 8'hA5;
    write_cfg();
    sw_closed = 8'h5A;
    cyc(3);
    check(pullup_en, 8'hA5, "pull-up enable");
    check(in_status, 8'hA5, "pulled-up pins");
    sw_closed = 8'hFF;
    conf_rst = 1'b1;
    cyc(1);
    conf_rst = 1'b0;
    cyc(1);
    check(pullup_en, 8'h00, "config reset");
    cyc(4);
  endtask : t_pullup
  // Rising on every pin, falling on every pin, then an edge-bit flip
  task automatic t_edges();
    for (int i = 0; i < 8; i++) begin
      sw_level[i] = 1'b1;
      expect_pulse(8'h01 << i);
    end
    edge_sel = 8'hFF;
    write_cfg();
    expect_quiet();
    for (int i = 0; i < 8; i++) begin
      sw_level[i] = 1'b0;
      expect_pulse(8'h01 << i);
    end
    edge_sel = 8'h00;
    write_cfg();
    expect_quiet();
    edge_sel = 8'h01;
    write_cfg();
    expect_pulse(8'h01);
    edge_sel = 8'h00;
    write_cfg();
    expect_quiet();
  endtask : t_edges
  task automatic t_pattern();
    logic [7:0] hi[6] = '{8'hF0, 8'hF0, 8'hF1, 8'hF0, 8'hE0, 8'hFF};
    logic [7:0] lo[6] = '{8'h0F, 8'h0E, 8'h0E, 8'h1F, 8'h1F, 8'hFF};
    logic       ex[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    sw_level = 8'h0F;
    for (int i = 0; i < 6; i++) begin
      pat_hi = hi[i] & 8'h7F;
      pat_lo = lo[i] & 8'h7F;
      write_cfg();
      cyc(2);
      check({7'h00, reset_req}, 8'h00, "pattern held off");
      pat_hi = hi[i];
      pat_lo = lo[i];
      write_cfg();
      cyc(2);
      check({7'h00, reset_req}, {7'h00, ex[i]}, "pattern match");
    end
    sw_level = 8'h1F;
    cyc(3);
    check({7'h00, reset_req}, 8'h01, "software reset");
    pat_hi = 8'hF0;
    pat_lo = 8'h0F;
    write_cfg();
    cyc(2);
    check({7'h00, reset_req}, 8'h00, "live pin mismatch");
    sw_level = 8'h0F;
    cyc(2);
    check({7'h00, reset_req}, 8'h01, "live pin match");
    pat_hi = 8'h00;
    pat_lo = 8'h00;
    write_cfg();
  endtask : t_pattern
  // Pin 0 filtered, pin 1 direct
  task automatic t_debounce();
    sw_level = 8'h00;
    deb = 8'h01;
    fast_sel = 1'b1;
    rc_pin0 = 1'b1;
    write_cfg();
    cyc(20);
    sw_level = 8'h03;
    expect_pulse(8'h02);
    check(in_status, 8'h02, "filtered pin still old");
    check({4'h0, cnt_clk}, 8'h02, "counter clocks early");
    check({7'h00, rc_set}, 8'h00, "rc early");
    expect_pulse(8'h01);
    check(in_status, 8'h03, "filtered pin accepted");
    check({4'h0, cnt_clk}, 8'h03, "counter clocks");
    check({7'h00, rc_set}, 8'h01, "rc enable set");
    fast_sel = 1'b0;
    sw_level = 8'h02;
    cyc(6);
    check(in_status, 8'h03, "slow filter holds");
    cyc(20);
    check(in_status, 8'h02, "slow filter accepts");
    check({7'h00, rc_set}, 8'h00, "rc released");
    // A glitch shorter than a tick period is seen by one sample at most
    fast_sel = 1'b1;
    sw_level = 8'h03;
    cyc(2);
    sw_level = 8'h02;
    cyc(12);
    check(in_status, 8'h02, "glitch rejected");
  endtask : t_debounce
  // Mid-run system reset: defaults return, and a pin held high gives no edge
  task automatic t_sysreset();
    pu = 8'hFF;
    edge_sel = 8'hFF;
    write_cfg();
    cyc(2);
    check(pullup_en, 8'hFF, "pull-up set before reset");
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    check(pullup_en, 8'h00, "pull-up after reset");
    repeat (3) begin
      cyc(1);
      check(irq, 8'h00, "false edge after reset");
    end
    sw_level[2] = 1'b1;
    expect_pulse(8'h04);
  endtask : t_sysreset
  // Main sequence
  initial begin
    cyc(5);
    sys_rst = 1'b0;
    t_pullup();
    t_edges();
    t_pattern();
    t_debounce();
    t_sysreset();
    print_verdict();
  end
endmodule : input_port_irq_reset_pattern_test
